//--- hdl/scaling_pkg.sv
package scaling_pkg;
    // register byte offsets
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] upper_off = 8'h04;
    localparam logic [7:0] lower_off = 8'h08;
    localparam logic [7:0] atop_off = 8'h0c;
    localparam logic [7:0] abot_off = 8'h10;
    localparam logic [7:0] tare_off = 8'h14;
    localparam logic [7:0] band_off = 8'h18;
    localparam logic [7:0] tcorr_off = 8'h1c;
    localparam logic [7:0] sup_a_off = 8'h20;
    localparam logic [7:0] sup_d_off = 8'h34;
    localparam logic [7:0] status_off = 8'h48;
    localparam logic [7:0] cmd_off = 8'h4c;
    // control field positions
    localparam int cat_lsb = 0;
    localparam int rng_lsb = 4;
    localparam int dp_lsb = 8;
    localparam int chk_lsb = 12;
    localparam int npt_lsb = 16;
    localparam int unit_bit = 20;
    localparam int cal_bit = 21;
    localparam int pfn_lsb = 24;
    // input categories
    localparam logic [2:0] voltage_category = 3'h0;
    localparam logic [2:0] current_category = 3'h1;
    localparam logic [2:0] rtd_category = 3'h2;
    localparam logic [2:0] thermocouple_select = 3'h3;
    localparam logic [2:0] pulse_category = 3'h4;
    // range choices: voltage 0..3 then sensor cal 4, current 0..1 then 2
    localparam logic [3:0] voltage_category_cal_range = 4'h4;
    localparam logic [3:0] amp_4_20_range = 4'h1;
    localparam logic [3:0] amp_cal_range = 4'h2;
    localparam logic [3:0] rtd_narrow_span = 4'h0;
    localparam logic [3:0] rtd_wide_span = 4'h1;
    localparam logic [3:0] rtd_kilo_ohm_span = 4'h2;
    localparam logic [3:0] tc_types = 4'h9;
    // range check modes
    localparam logic [2:0] no_check = 3'h0;
    localparam logic [2:0] display_limit_check = 3'h1;
    localparam logic [2:0] measuring_span_check = 3'h2;
    localparam logic [2:0] tolerance_five_check = 3'h3;
    localparam logic [2:0] tolerance_ten_check = 3'h4;
    // pulse functions
    localparam logic [1:0] pulse_rate_mode = 2'h0;
    localparam logic [1:0] count_up_mode = 2'h2;
    localparam logic [1:0] count_down_mode = 2'h3;
    // value limits and reset values
    localparam int display_minimum = -1999;
    localparam int display_maximum = 9999;
    localparam int analog_min = -1999;
    localparam int analog_max = 9999;
    localparam int band_max = 99;
    localparam int upper_reset = 1000;
    localparam int atop_reset = 1000;
    localparam int corr_c_max = 200;
    localparam int corr_f_max = 36;
    localparam int under_4_20 = 100;
    localparam int tol_five_pct = 5;
    localparam int tol_ten_pct = 10;
    localparam int rtd_narrow_lo = -500;
    localparam int rtd_narrow_hi = 2000;
    localparam int rtd_wide_lo = -2000;
    localparam int rtd_wide_hi = 8500;
    localparam int n_support = 5;

    typedef struct packed {
        logic valid;
        logic signed [15:0] value;
    } sample_s;

    typedef struct packed {
        logic valid;
        logic bars_top;
        logic bars_bottom;
        logic [1:0] decimals;
        logic signed [15:0] value;
    } display_s;
endpackage

//--- hdl/measurement_scaling_monitor.sv
`timescale 1ns/10ps
// Functional notes
// R1: input category selector with five choices, illegal codes ignored
// R2: voltage ranges 0-10, 0-2, 0-1 V, 0-50 mV, sensor cal; default 0-10
// R3: current ranges 0-20, 4-20 mA, sensor cal; default 0-20 mA
// R4: upper and lower scale values -1999..9999, upper defaults 1000
// R5: sensor cal keeps entered value or captures present analog input
// R6: decimal point position zero to three fractional digits
// R7: analog top and bottom points -19.99..99.99, defaults 10.00, 00.00
// R8: tare offset -1999..9999 added after linearisation
// R9: zero shown while magnitude within null band up to 99
// R10: overflow shows top bars, underflow shows bottom bars
// R11: 4-20 mA input below 1 mA flagged as underflow; with no check selected the flag is cleared
// R12: with no check, clamp to display minimum or maximum
// R13: display limit check flags leaving display range
// R14: span check flags leaving scale span, plus display and converter
// R15: tolerance checks allow 5% or 10% beyond span, plus display
// R16: zero to five extra points; only enabled points take part
// R17: support analog values preset by range; operator keeps them ascending
// R18: three resistance thermometer variants with their spans
// R19: nine thermocouple curve types selectable
// R20: temperature shown in Celsius or Fahrenheit
// R21: correction -20.0..20.0 C or -36..36 F, rounded on unit change
// R22: pulse functions rate, speed, count up, count down
// R23: piecewise-linear interpolation between consecutive enabled points
module measurement_scaling_monitor
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire scaling_pkg::sample_s sample_i,
    output scaling_pkg::display_s display_o
);
    import scaling_pkg::*;

    // ******************************************
    // configuration state
    // ******************************************
    logic [2:0] category;
    logic [3:0] range_sel;
    logic [1:0] decimals;
    logic [2:0] check_mode;
    logic [2:0] extra_point_count;
    logic temp_scale_select;
    logic measure_adjust;
    logic [1:0] pulse_fn;
    logic signed [15:0] upper_scale_value;
    logic signed [15:0] lower_scale_value;
    logic signed [15:0] analog_top_point;
    logic signed [15:0] analog_bottom_point;
    logic signed [15:0] tare_offset;
    logic [6:0] null_band_width;
    logic signed [15:0] temp_corr;
    logic signed [15:0] support_analog_value [n_support];
    logic signed [15:0] support_display_value [n_support];
    logic signed [15:0] last_sample;
    logic signed [31:0] pulse_count;
    logic signed [31:0] next_count;

    logic wr;
    logic rd;
    logic [4:0] sup_idx;
    logic [31:0] wd;
    logic [2:0] w_cat;
    logic [3:0] w_rng;
    logic [2:0] w_npt;
    logic [2:0] w_chk;
    logic range_ok;
    logic cal_active;

    function automatic logic signed [15:0] clamp(input int v, input int lo,
                                                input int hi);
        int r;
        r = v;
        if (v < lo)
            r = lo;
        if (v > hi)
            r = hi;
        return r[15:0];
    endfunction

    // rounds to nearest, halves away from zero
    function automatic int rdiv(input int num, input int den);
        int r;
        if (num < 0)
            r = (num - den / 2) / den;
        else
            r = (num + den / 2) / den;
        return r;
    endfunction

    // byte lanes gated by sel, value registers below hold the low half, control uses bits up to 25
    assign wd = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    // parked beyond every point outside the window, so no alias
    assign sup_idx = (wb_adr_i < status_off) ?
                     5'((wb_adr_i - sup_a_off) >> 2) : 5'h1f;
    assign w_cat = wd[cat_lsb +: 3];
    assign w_rng = wd[rng_lsb +: 4];
    assign w_npt = wd[npt_lsb +: 3];
    assign w_chk = wd[chk_lsb +: 3];

    // only legal range codes for the category are accepted
    always_comb
    begin
        unique case (w_cat)
            // R2 voltage ranges
            voltage_category: range_ok = w_rng <= voltage_category_cal_range;
            // R3 current ranges
            current_category: range_ok = w_rng <= amp_cal_range;
            // R18 rtd variants
            rtd_category: range_ok = w_rng <= rtd_kilo_ohm_span;
            // R19 thermocouple curves
            thermocouple_select: range_ok = w_rng < tc_types;
            default: range_ok = w_rng == 4'h0;
        endcase
    end

    assign cal_active = (category == voltage_category &&
                         range_sel == voltage_category_cal_range) ||
                        (category == current_category &&
                         range_sel == amp_cal_range);

    // total including the present sample, so the shown count is current
    assign next_count = pulse_fn == count_down_mode ?
                        pulse_count - 32'(sample_i.value) :
                        pulse_count + 32'(sample_i.value);

    // ******************************************
    // control register
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            category <= voltage_category;
            range_sel <= 4'h0;
            decimals <= 2'h0;
            check_mode <= no_check;
            extra_point_count <= 3'h0;
            temp_scale_select <= 1'b0;
            measure_adjust <= 1'b0;
            pulse_fn <= pulse_rate_mode;
        end
        else if (wr && wb_adr_i == ctrl_off)
        begin
            // R1 five categories only
            if (w_cat <= pulse_category && range_ok)
            begin
                category <= w_cat;
                range_sel <= w_rng;
            end
            // R6 decimal point
            decimals <= wd[dp_lsb +: 2];
            if (w_chk <= tolerance_ten_check)
                check_mode <= w_chk;
            // R16 up to five extra points
            if (w_npt <= 3'(n_support))
                extra_point_count <= w_npt;
            // R20 unit
            temp_scale_select <= wd[unit_bit];
            measure_adjust <= wd[cal_bit];
            // R22 pulse functions
            pulse_fn <= wd[pfn_lsb +: 2];
        end
    end

    // ******************************************
    // scale and offset registers
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            upper_scale_value <= 16'(upper_reset);
            lower_scale_value <= 16'h0000;
            analog_top_point <= 16'(atop_reset);
            analog_bottom_point <= 16'h0000;
            tare_offset <= 16'h0000;
            null_band_width <= 7'h00;
        end
        else if (wr)
        begin
            // R4 scale limits
            if (wb_adr_i == upper_off)
                upper_scale_value <= clamp(int'($signed(wd[15:0])),
                                           display_minimum, display_maximum);
            if (wb_adr_i == lower_off)
                lower_scale_value <= clamp(int'($signed(wd[15:0])),
                                           display_minimum, display_maximum);
            // R7 analog points in hundredths
            if (wb_adr_i == atop_off)
                analog_top_point <= clamp(int'($signed(wd[15:0])),
                                          analog_min, analog_max);
            if (wb_adr_i == abot_off)
                analog_bottom_point <= clamp(int'($signed(wd[15:0])),
                                             analog_min, analog_max);
            // R5 capture the live input as a scaling point
            if (wb_adr_i == cmd_off && cal_active && measure_adjust)
            begin
                if (wd[0])
                    analog_top_point <= last_sample;
                if (wd[1])
                    analog_bottom_point <= last_sample;
            end
            // R8 tare limits
            if (wb_adr_i == tare_off)
                tare_offset <= clamp(int'($signed(wd[15:0])),
                                     display_minimum, display_maximum);
            // R9 band limit
            if (wb_adr_i == band_off)
                null_band_width <= 7'(clamp(int'(wd[7:0]), 0, band_max));
        end
    end

    // ******************************************
    // temperature correction
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            temp_corr <= 16'h0000;
        else if (wr && wb_adr_i == tcorr_off)
            temp_corr <= temp_scale_select ?
                clamp(int'($signed(wd[15:0])), -corr_f_max, corr_f_max) :
                clamp(int'($signed(wd[15:0])), -corr_c_max, corr_c_max);
        // R21 rounded on unit change, tenths of C against whole F
        else if (wr && wb_adr_i == ctrl_off &&
                 wd[unit_bit] != temp_scale_select)
            temp_corr <= wd[unit_bit] ?
                clamp(rdiv(int'(temp_corr) * 9, 50), -corr_f_max, corr_f_max) :
                clamp(rdiv(int'(temp_corr) * 50, 9), -corr_c_max, corr_c_max);
    end

    // ******************************************
    // support points
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < n_support; k++)
            begin
                support_analog_value[k] <= 16'(atop_reset * (k + 1) / 6);
                support_display_value[k] <= 16'(upper_reset * (k + 1) / 6);
            end
        end
        else if (wr && wb_adr_i == ctrl_off && range_ok &&
                 w_cat <= current_category)
        begin
            // R17 preset evenly over the nominal span of the range
            for (int k = 0; k < n_support; k++)
                support_analog_value[k] <= 16'(rdiv(nominal_top(w_cat, w_rng)
                                                    * (k + 1), 6));
        end
        else if (wr && wb_adr_i >= sup_a_off && sup_idx < 5'(2 * n_support))
        begin
            // R16 only enabled points are writable
            if (sup_idx < 5'(n_support) &&
                sup_idx < 5'(extra_point_count))
                support_analog_value[3'(sup_idx)] <=
                    clamp(int'($signed(wd[15:0])), analog_min, analog_max);
            else if (sup_idx >= 5'(n_support) &&
                     sup_idx - 5'(n_support) < 5'(extra_point_count))
                support_display_value[3'(sup_idx - 5'(n_support))] <=
                    clamp(int'($signed(wd[15:0])),
                          display_minimum, display_maximum);
        end
    end

    // nominal range end in hundredths of the range unit
    function automatic int nominal_top(input logic [2:0] c,
                                       input logic [3:0] r);
        int t;
        t = 1000;
        if (c == voltage_category && r == 4'h1)
            t = 200;
        if (c == voltage_category && r == 4'h2)
            t = 100;
        if (c == voltage_category && r == 4'h3)
            t = 5000;
        if (c == current_category)
            t = 2000;
        return t;
    endfunction

    // ******************************************
    // processing path
    // ******************************************
    int px [7];
    int py [7];
    int x;
    int seg;
    int lin;
    int val;
    int span;
    int tol;
    int lo_lim;
    int hi_lim;
    logic over;
    logic under;

    always_comb
    begin
        x = int'(sample_i.value);
        // R23 chain of enabled points from bottom through supports to top
        for (int k = 0; k < 7; k++)
        begin
            if (k == 0)
            begin
                px[k] = int'(analog_bottom_point);
                py[k] = int'(lower_scale_value);
            end
            else if (k <= int'(extra_point_count))
            begin
                px[k] = int'(support_analog_value[k - 1]);
                py[k] = int'(support_display_value[k - 1]);
            end
            else
            begin
                px[k] = int'(analog_top_point);
                py[k] = int'(upper_scale_value);
            end
        end
        seg = 0;
        // R23 pick the segment holding the sample
        for (int k = 1; k <= n_support; k++)
            if (k <= int'(extra_point_count) && x > px[k])
                seg = k;
        if (px[seg + 1] == px[seg])
            lin = py[seg];
        else
            lin = py[seg] + (x - px[seg]) * (py[seg + 1] - py[seg]) /
                  (px[seg + 1] - px[seg]);
        span = px[6] - px[0];
        if (span < 0)
            span = -span;
        tol = 0;
        lo_lim = rtd_wide_lo;
        hi_lim = rtd_wide_hi;
        over = 1'b0;
        under = 1'b0;
        if (category == rtd_category || category == thermocouple_select)
        begin
            // R18 span per variant, input in tenths of degree C
            if (range_sel == rtd_narrow_span)
            begin
                lo_lim = rtd_narrow_lo;
                hi_lim = rtd_narrow_hi;
            end
            if (category == rtd_category)
            begin
                over = x > hi_lim;
                under = x < lo_lim;
            end
            val = x + (temp_scale_select ? 0 : int'(temp_corr));
            // R20 Fahrenheit conversion
            if (temp_scale_select)
                val = rdiv(val * 9, 5) + 320 + int'(temp_corr) * 10;
            if (!(category == rtd_category &&
                  range_sel == rtd_narrow_span))
                val = rdiv(val, 10);
        end
        else if (category == pulse_category && pulse_fn[1])
            val = next_count[31] ? display_minimum :
                  (next_count > display_maximum ? display_maximum :
                   int'(next_count));
        else
            val = lin;
        // R8 tare after linearisation
        val = val + int'(tare_offset);
        unique case (check_mode)
            // R14 span check plus converter limits
            measuring_span_check:
            begin
                over = over | (x > px[6]) | (sample_i.value == 16'sh7fff);
                under = under | (x < px[0]) | (sample_i.value == -16'sh8000);
            end
            // R15 tolerance bands
            tolerance_five_check, tolerance_ten_check:
            begin
                tol = span * (check_mode == tolerance_five_check ?
                              tol_five_pct : tol_ten_pct) / 100;
                over = over | (x > px[6] + tol);
                under = under | (x < px[0] - tol);
            end
            default:
            begin
            end
        endcase
        // R11 open loop on live zero current
        if (category == current_category && range_sel == amp_4_20_range &&
            x < under_4_20)
            under = 1'b1;
        if (check_mode == no_check)
        begin
            // R12 clamp instead of flagging
            over = 1'b0;
            under = 1'b0;
            val = int'(clamp(val, display_minimum, display_maximum));
        end
        else
        begin
            // R13 display range always watched when checking
            over = over | (val > display_maximum);
            under = under | (val < display_minimum);
        end
        // R9 zero band
        if (val <= int'(null_band_width) && val >= -int'(null_band_width))
            val = 0;
    end

    // ******************************************
    // outputs and counters
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            display_o <= '0;
            last_sample <= 16'h0000;
        end
        else
        begin
            display_o.valid <= sample_i.valid;
            if (sample_i.valid)
            begin
                last_sample <= sample_i.value;
                // R10 over wins, value still loaded alongside the bars
                display_o.bars_top <= over;
                display_o.bars_bottom <= under & ~over;
                display_o.decimals <= decimals;
                display_o.value <= clamp(val, display_minimum,
                                         display_maximum);
            end
        end
    end

    // counter takes each sample as a count of new pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pulse_count <= 32'h0000_0000;
        else if (wr && wb_adr_i == cmd_off && wd[2])
            pulse_count <= 32'h0000_0000;
        // R22 counting up and down
        else if (sample_i.valid && category == pulse_category && pulse_fn[1])
            pulse_count <= next_count;
    end

    // ******************************************
    // bus read and ack
    // ******************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (rd)
            begin
                wb_dat_o <= 32'h0000_0000;
                unique case (wb_adr_i)
                    ctrl_off: wb_dat_o <= {6'h00, pulse_fn, 2'h0,
                        measure_adjust, temp_scale_select, 1'b0,
                        extra_point_count, 1'b0, check_mode, 2'h0,
                        decimals, range_sel, 1'b0, category};
                    upper_off: wb_dat_o <= 32'(upper_scale_value);
                    lower_off: wb_dat_o <= 32'(lower_scale_value);
                    atop_off: wb_dat_o <= 32'(analog_top_point);
                    abot_off: wb_dat_o <= 32'(analog_bottom_point);
                    tare_off: wb_dat_o <= 32'(tare_offset);
                    band_off: wb_dat_o <= {25'h0, null_band_width};
                    tcorr_off: wb_dat_o <= 32'(temp_corr);
                    status_off: wb_dat_o <= {13'h0, display_o.bars_top,
                        display_o.bars_bottom, cal_active,
                        display_o.value};
                    default:
                        if (wb_adr_i >= sup_a_off &&
                            sup_idx < 5'(n_support))
                            wb_dat_o <= 32'(support_analog_value[3'(sup_idx)]);
                        else if (wb_adr_i >= sup_a_off &&
                                 sup_idx < 5'(2 * n_support))
                            wb_dat_o <= 32'(support_display_value
                                [3'(sup_idx - 5'(n_support))]);
                endcase
            end
        end
    end
endmodule

//--- test/msm_checker.sv
`timescale 1ns/10ps
// ********************************
// bus timing and display output checks
// ********************************
module msm_checker
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire scaling_pkg::sample_s sample_i,
    input wire scaling_pkg::display_s display_o
);
    import scaling_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_cause:
        assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_disp_follow:
        assert property (sample_i.valid |=> display_o.valid)
        else $error("display late");
    a_disp_cause:
        assert property (display_o.valid |-> $past(sample_i.valid))
        else $error("display without sample");
    a_value_span:
        assert property (display_o.value >= display_minimum
            && display_o.value <= display_maximum) else $error("value span");
    a_bars_single:
        assert property (!(display_o.bars_top && display_o.bars_bottom))
        else $error("both bars");
    a_fields_hold:
        assert property (!$past(sample_i.valid) |-> $stable(display_o.value)
            && $stable(display_o.decimals)) else $error("fields moved");
endmodule
bind measurement_scaling_monitor msm_checker i_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sample_i(sample_i), .display_o(display_o));

//--- test/sensor_front_end.sv
`timescale 1ns/10ps
module sensor_front_end
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [15:0] level_i,
    output scaling_pkg::sample_s sample_o = '0
);
    import scaling_pkg::*;
    // stale value inverted so no old conversion passes for a new one
    always_ff @(posedge clk_i)
    begin
        sample_o.valid <= go_i;
        sample_o.value <= go_i ? level_i : ~sample_o.value;
    end
endmodule

//--- test/measurement_scaling_monitor_tb_top.sv
`timescale 1ns/10ps
module measurement_scaling_monitor_tb_top;
    import scaling_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdat, dat;
    logic [15:0] lvl = '0;
    logic ack;
    sample_s smp;
    display_s disp;
    int err_total = 0, n_compared = 0, cyc_n = 0;
    measurement_scaling_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
        .sample_i(smp), .display_o(disp));
    sensor_front_end i_sensor (.clk_i(clk_i), .go_i(go), .level_i(lvl),
        .sample_o(smp));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat;
        {cyc, stb, we} <= 3'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(rdat, e);
    endtask
    // m masks out the value where only the bars are defined
    task sm(input int v, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        go <= 1'b1;
        lvl <= v[15:0];
        @(posedge clk_i);
        go <= 1'b0;
        do @(posedge clk_i); while (disp.valid !== 1'b1);
        cmp({12'h0, disp.bars_top, disp.bars_bottom, disp.decimals,
            disp.value} & m, e);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(upper_off, 32'h3e8);
        rd(atop_off, 32'h3e8);
        rd(ctrl_off, 32'h0);
        rd(8'hf0, 32'h0);
        bus(1'b1, ctrl_off, 32'h5);
        rd(ctrl_off, 32'h0);
        sm(500, 32'h1f4, '1);
        bus(1'b1, tare_off, 32'h5);
        sm(500, 32'h1f9, '1);
        bus(1'b1, tare_off, 32'h0);
        bus(1'b1, band_off, 32'ha);
        sm(10, 32'h0, '1);
        sm(11, 32'hb, '1);
        bus(1'b1, band_off, 32'h0);
        bus(1'b1, upper_off, 32'h2328);
        sm(2000, 32'h270f, '1);
        bus(1'b1, ctrl_off, 32'h1000);
        sm(2000, 32'h80000, 32'hc0000);
        bus(1'b1, upper_off, 32'h3e8);
        bus(1'b1, ctrl_off, 32'h3300);
        sm(1040, 32'h30410, '1);
        sm(1060, 32'h80000, 32'hc0000);
        bus(1'b1, ctrl_off, 32'h2000);
        sm(1001, 32'h80000, 32'hc0000);
        bus(1'b1, ctrl_off, 32'h1011);
        sm(50, 32'h40000, 32'hc0000);
        bus(1'b1, ctrl_off, 32'h10010);
        rd(sup_a_off, 32'h21);
        bus(1'b1, sup_a_off, 32'hc8);
        bus(1'b1, sup_d_off, 32'h258);
        bus(1'b1, 8'h24, 32'h5);
        rd(8'h24, 32'h43);
        sm(100, 32'h12c, '1);
        sm(600, 32'h320, '1);
        bus(1'b1, ctrl_off, 32'h200040);
        sm(400, 32'h190, '1);
        bus(1'b1, cmd_off, 32'h1);
        rd(atop_off, 32'h190);
        sm(200, 32'h1f4, '1);
        rd(status_off, 32'h101f4);
        bus(1'b1, ctrl_off, 32'h2);
        bus(1'b1, tcorr_off, 32'h64);
        sm(1000, 32'h44c, '1);
        bus(1'b1, ctrl_off, 32'h100002);
        rd(tcorr_off, 32'h12);
        sm(1000, 32'h8fc, '1);
        bus(1'b1, ctrl_off, 32'h2000004);
        sm(7, 32'h7, '1);
        sm(5, 32'hc, '1);
        bus(1'b1, cmd_off, 32'h4);
        sm(3, 32'h3, '1);
        tally_and_finish();
    end
endmodule
